// File: design/cls_can_loopback.sv
`timescale 1ns/1ps
// Function
// [RULE1] In loop-back, both transmit pins stay recessive.
// [RULE2] In loop-back, merged node transmits feed both node receive inputs.
// [RULE3] In loop-back, external receive pins are ignored.
// [RULE4] Loop-back is on only when both timing loop-back bits are 1.
// [RULE5] If either loop-back bit is 0, normal pin paths are used.
// [RULE6] Each message object has its own single-try enable bit.
// [RULE7] Single-try objects lose their transmit request when their frame starts.
// [RULE8] Single-try objects are never retransmitted after an error.
// [RULE9] Only objects marked valid are offered for transmission.
// [RULE10] Two-bit fields: 10 sets, 01 resets.
// [RULE11] Merged loop-back level is the wired-AND of both transmit signals.
module cls_can_loopback #(
	parameter int NOBJ = cls_pkg::NOBJ,
	parameter int IW   = cls_pkg::OBJ_IW
) (
	input  wire logic                      clk,
	input  wire logic                      rst_b,
	input  wire logic                      ce,
	input  wire logic [cls_pkg::ADDR_W-1:0] awaddr,
	input  wire logic                      awvalid,
	output logic                           awready,
	input  wire logic [31:0]               wdata,
	input  wire logic [3:0]                wstrb,
	input  wire logic                      wvalid,
	output logic                           wready,
	output logic      [1:0]                bresp,
	output logic                           bvalid,
	input  wire logic                      bready,
	input  wire logic [cls_pkg::ADDR_W-1:0] araddr,
	input  wire logic                      arvalid,
	output logic                           arready,
	output logic      [31:0]               rdata,
	output logic      [1:0]                rresp,
	output logic                           rvalid,
	input  wire logic                      rready,
	input  wire logic                      nodeTxA,
	input  wire logic                      nodeTxB,
	output logic                           nodeRxA,
	output logic                           nodeRxB,
	output logic                           txPinA,
	output logic                           txPinB,
	input  wire logic                      rxPinA,
	input  wire logic                      rxPinB,
	output logic                           txReqValid,
	output logic      [IW-1:0]             txReqObj,
	input  wire logic                      frameStart,
	input  wire logic                      frameDone,
	input  wire logic                      frameError,
	input  wire logic [IW-1:0]             frameObj
);
	// ---------------------------------------------------------------
	// Address decode
	// ---------------------------------------------------------------
	function automatic logic objHit(input logic [cls_pkg::ADDR_W-1:0] a);
		objHit = (a >= cls_pkg::OFF_OBJ_BASE) &&
			(a < cls_pkg::OFF_OBJ_BASE + cls_pkg::ADDR_W'(4 * NOBJ)) && (a[1:0] == 2'h0);
	endfunction : objHit

	function automatic logic [IW-1:0] objIdx(input logic [cls_pkg::ADDR_W-1:0] a);
		logic [cls_pkg::ADDR_W-1:0] off;
		off    = a - cls_pkg::OFF_OBJ_BASE;
		objIdx = off[IW+1:2];
	endfunction : objIdx

	logic [cls_pkg::TIM_W-1:0] timA_q, timB_q;
	logic                      bvalid_q, rvalid_q, rdPend_q;
	logic [1:0]                bresp_q, rresp_q;
	logic [31:0]               rdata_q;
	logic [cls_pkg::ADDR_W-1:0] rdAddr_q;
	logic                      nodeRxA_q, nodeRxB_q, txPinA_q, txPinB_q;
	logic                      wrTake, rdTake, wrTimA, wrTimB, wrObj, wrHit;
	logic [31:0]               statWord, rdWord;
	logic [31:0]               objRd;
	logic [NOBJ-1:0]           validVec, reqVec, onceVec, readyVec;
	logic                      lbActive, lbMerged, hwClr;

	// ---------------------------------------------------------------
	// AXI4-Lite write channel
	// ---------------------------------------------------------------
	// Address and data are taken together; one write outstanding keeps it simple
	assign wrTake  = ce && awvalid && wvalid && !bvalid_q;
	assign awready = wrTake;
	assign wready  = wrTake;
	assign wrTimA  = wrTake && awaddr == cls_pkg::OFF_TIM_A;
	assign wrTimB  = wrTake && awaddr == cls_pkg::OFF_TIM_B;
	assign wrObj   = wrTake && objHit(awaddr) && wstrb[0];
	assign wrHit   = wrTimA || wrTimB || (objHit(awaddr) && wrTake) ||
		awaddr == cls_pkg::OFF_STAT;
	assign bvalid  = bvalid_q;
	assign bresp   = bresp_q;

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			bvalid_q <= 1'b0;
			bresp_q  <= cls_pkg::RESP_OKAY;
		end else if (ce) begin
			if (wrTake) begin
				bvalid_q <= 1'b1;
				bresp_q  <= wrHit ? cls_pkg::RESP_OKAY : cls_pkg::RESP_SLVERR;
			end else if (bready) bvalid_q <= 1'b0;
		end
	end

	// Timing registers honour the two low byte lanes
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			timA_q <= cls_pkg::TIM_RST;
			timB_q <= cls_pkg::TIM_RST;
		end else if (ce) begin
			for (int b = 0; b < 2; b++) begin
				if (wrTimA && wstrb[b]) timA_q[8*b +: 8] <= wdata[8*b +: 8];
				if (wrTimB && wstrb[b]) timB_q[8*b +: 8] <= wdata[8*b +: 8];
			end
		end
	end

	// ---------------------------------------------------------------
	// AXI4-Lite read channel
	// ---------------------------------------------------------------
	// Extra pending stage covers the registered object read port
	assign rdTake  = ce && arvalid && !rvalid_q && !rdPend_q;
	assign arready = rdTake;
	assign statWord = {{(24 - IW){1'b0}}, txReqObj, 6'h0, txReqValid, lbActive};
	assign rdWord = (rdAddr_q == cls_pkg::OFF_TIM_A) ? {16'h0, timA_q} :
		(rdAddr_q == cls_pkg::OFF_TIM_B) ? {16'h0, timB_q} :
		(rdAddr_q == cls_pkg::OFF_STAT)  ? statWord :
		objHit(rdAddr_q) ? objRd : 32'h0;
	assign rvalid = rvalid_q;
	assign rdata  = rdata_q;
	assign rresp  = rresp_q;

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			rdPend_q <= 1'b0;
			rvalid_q <= 1'b0;
			rdAddr_q <= '0;
			rdata_q  <= 32'h0;
			rresp_q  <= cls_pkg::RESP_OKAY;
		end else if (ce) begin
			rdPend_q <= rdTake;
			if (rdTake) rdAddr_q <= araddr;
			if (rdPend_q) begin
				rvalid_q <= 1'b1;
				rdata_q  <= rdWord;
				rresp_q  <= (rdAddr_q == cls_pkg::OFF_TIM_A || rdAddr_q == cls_pkg::OFF_TIM_B ||
					rdAddr_q == cls_pkg::OFF_STAT || objHit(rdAddr_q)) ?
					cls_pkg::RESP_OKAY : cls_pkg::RESP_SLVERR;
			end else if (rready) rvalid_q <= 1'b0;
		end
	end

	// ---------------------------------------------------------------
	// Loop-back path
	// ---------------------------------------------------------------
	assign lbActive = timA_q[cls_pkg::LB_SEL_BIT] && timB_q[cls_pkg::LB_SEL_BIT]; // [RULE4] [RULE5]
	assign lbMerged = nodeTxA & nodeTxB; // Dominant low wins on both sides [RULE11]

	// Pins are retimed so the transceiver never sees a decode glitch
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			txPinA_q  <= 1'b1;
			txPinB_q  <= 1'b1;
			nodeRxA_q <= 1'b1;
			nodeRxB_q <= 1'b1;
		end else if (ce) begin
			txPinA_q  <= lbActive ? 1'b1 : nodeTxA; // [RULE1] [RULE5]
			txPinB_q  <= lbActive ? 1'b1 : nodeTxB; // [RULE1] [RULE5]
			nodeRxA_q <= lbActive ? lbMerged : rxPinA; // [RULE2] [RULE3]
			nodeRxB_q <= lbActive ? lbMerged : rxPinB; // [RULE2] [RULE3]
		end
	end
	assign txPinA  = txPinA_q;
	assign txPinB  = txPinB_q;
	assign nodeRxA = nodeRxA_q;
	assign nodeRxB = nodeRxB_q;

	// ---------------------------------------------------------------
	// Message objects and transmit selection
	// ---------------------------------------------------------------
	// A completed frame retires the request unless software sets it that cycle; an error leaves it
	// standing for retry; a single-try object has already lost it at frame start
	assign hwClr = (frameStart && onceVec[frameObj]) || frameDone; // [RULE7] [RULE8]

	cls_obj_ctrl #(.NOBJ(NOBJ), .IW(IW)) u_cls_obj_ctrl (
		.clk      (clk),
		.rst_b    (rst_b),
		.ce       (ce),
		.swWr     (wrObj),
		.swIdx    (objIdx(awaddr)),
		.swData   (wdata[cls_pkg::OBJ_W-1:0]),
		.hwClr    (hwClr),
		.hwIdx    (frameObj),
		.rdEn     (rdTake),
		.rdIdx    (objIdx(araddr)),
		.rdData_q (objRd),
		.validVec_q (validVec),
		.reqVec_q   (reqVec),
		.onceVec_q  (onceVec)
	);

	// Lowest-numbered valid pending object is offered first
	assign readyVec   = validVec & reqVec; // [RULE9]
	assign txReqValid = |readyVec;
	always_comb begin
		txReqObj = '0;
		for (int i = NOBJ - 1; i >= 0; i--) begin
			if (readyVec[i]) txReqObj = IW'(i);
		end
	end

	// ---------------------------------------------------------------
	// Checks
	// ---------------------------------------------------------------
	AST_LB_TX_RECESSIVE: assert property (@(posedge clk) disable iff (!rst_b) // [RULE1]
		ce && lbActive |=> txPinA && txPinB)
		else $error("transmit pin not recessive in loop-back");
	AST_LB_MERGE: assert property (@(posedge clk) disable iff (!rst_b) // [RULE2]
		ce && lbActive |=> nodeRxA == nodeRxB && nodeRxA == ($past(nodeTxA) & $past(nodeTxB)))
		else $error("loop-back receive not the merged transmit");
	AST_LB_IGNORE_PIN: assert property (@(posedge clk) disable iff (!rst_b) // [RULE3]
		ce && lbActive && nodeTxA && nodeTxB |=> nodeRxA && nodeRxB)
		else $error("external receive level leaked in loop-back");
	AST_LB_BOTH_BITS: assert property (@(posedge clk) disable iff (!rst_b) // [RULE4]
		ce && timA_q[cls_pkg::LB_SEL_BIT] && timB_q[cls_pkg::LB_SEL_BIT]
		|=> txPinA && txPinB && nodeRxB == ($past(nodeTxA) & $past(nodeTxB)))
		else $error("loop-back off although both bits are set");
	AST_LB_OFF_NORMAL: assert property (@(posedge clk) disable iff (!rst_b) // [RULE5]
		ce && !(timA_q[cls_pkg::LB_SEL_BIT] && timB_q[cls_pkg::LB_SEL_BIT])
		|=> txPinA == $past(nodeTxA) && txPinB == $past(nodeTxB) &&
		nodeRxA == $past(rxPinA) && nodeRxB == $past(rxPinB))
		else $error("normal pin path broken");
	AST_ONCE_CLEAR: assert property (@(posedge clk) disable iff (!rst_b) // [RULE7]
		ce && frameStart && onceVec[frameObj] && !wrObj |=> !reqVec[$past(frameObj)])
		else $error("single-try request not cleared at frame start");
	AST_ONCE_NO_RETRY: assert property (@(posedge clk) disable iff (!rst_b) // [RULE8]
		ce && frameStart && onceVec[frameObj] && !wrObj ##1 !wrObj[*2]
		|-> !readyVec[$past(frameObj, 2)])
		else $error("single-try object offered again");
	AST_VALID_ONLY: assert property (@(posedge clk) disable iff (!rst_b) // [RULE9]
		txReqValid |-> validVec[txReqObj] && reqVec[txReqObj])
		else $error("invalid object offered for transmit");
	AST_RETRY_KEEP: assert property (@(posedge clk) disable iff (!rst_b) // [RULE8]
		ce && frameError && !frameDone && !frameStart && reqVec[frameObj] && !wrObj
		|=> reqVec[$past(frameObj)])
		else $error("request dropped on error");
endmodule : cls_can_loopback

// File: shared/cls_pkg.sv
package cls_pkg;
	// ---------------------------------------------------------------
	// Register map (byte addresses, one aligned word each)
	// ---------------------------------------------------------------
	localparam int          ADDR_W       = 12;
	localparam logic [11:0] OFF_TIM_A    = 12'h000; // node_a_timing_reg
	localparam logic [11:0] OFF_TIM_B    = 12'h004; // node_b_timing_reg
	localparam logic [11:0] OFF_STAT     = 12'h008; // block status, read only
	localparam logic [11:0] OFF_OBJ_BASE = 12'h100; // object_fifo_gateway_ctrl[n]

	// ---------------------------------------------------------------
	// Field layouts and reset values
	// ---------------------------------------------------------------
	localparam int          TIM_W        = 16;
	localparam logic [15:0] TIM_RST      = 16'h0000;
	localparam int          LB_SEL_BIT   = 8;       // loopback_select_bit
	localparam int          NOBJ         = 32;
	localparam int          OBJ_IW       = 5;
	localparam int          OBJ_VAL_LSB  = 0;       // object_valid_field [1:0]
	localparam int          OBJ_REQ_LSB  = 2;       // transmit_request_flag [3:2]
	localparam int          OBJ_ONCE_BIT = 4;       // single_try_enable
	localparam int          OBJ_W        = 5;
	localparam int          STAT_LB_BIT  = 0;
	localparam int          STAT_RQ_BIT  = 1;
	localparam int          STAT_OBJ_LSB = 8;

	// Two-bit control field codes
	localparam logic [1:0]  FLD_SET      = 2'h2;
	localparam logic [1:0]  FLD_CLR      = 2'h1;

	// AXI responses
	localparam logic [1:0]  RESP_OKAY    = 2'h0;
	localparam logic [1:0]  RESP_SLVERR  = 2'h2;
endpackage : cls_pkg

// File: design/cls_obj_ctrl.sv
`timescale 1ns/1ps
// Per-object control flags with a registered read port
module cls_obj_ctrl #(
	parameter int NOBJ = cls_pkg::NOBJ,
	parameter int IW   = cls_pkg::OBJ_IW
) (
	input  wire logic                   clk,
	input  wire logic                   rst_b,
	input  wire logic                   ce,
	input  wire logic                   swWr,
	input  wire logic [IW-1:0]          swIdx,
	input  wire logic [cls_pkg::OBJ_W-1:0] swData,
	input  wire logic                   hwClr,
	input  wire logic [IW-1:0]          hwIdx,
	input  wire logic                   rdEn,
	input  wire logic [IW-1:0]          rdIdx,
	output logic      [31:0]            rdData_q,
	output logic      [NOBJ-1:0]        validVec_q,
	output logic      [NOBJ-1:0]        reqVec_q,
	output logic      [NOBJ-1:0]        onceVec_q
);
	logic [1:0] swVal;
	logic [1:0] swRq;
	logic [31:0] rdData_d;

	// Field decode of the software write
	assign swVal = swData[cls_pkg::OBJ_VAL_LSB +: 2];
	assign swRq  = swData[cls_pkg::OBJ_REQ_LSB +: 2];

	// -----------------------------------------------------------------
	// One flag set per object
	// -----------------------------------------------------------------
	for (genvar i = 0; i < NOBJ; i++) begin : gObj
		wire hit    = swWr && (swIdx == IW'(i));
		wire setRq  = hit && (swRq == cls_pkg::FLD_SET);
		wire clrRq  = (hit && (swRq == cls_pkg::FLD_CLR)) || (hwClr && (hwIdx == IW'(i)));
		// Software set beats a same-cycle hardware clear so a request is never lost
		always_ff @(posedge clk) begin
			if (!rst_b) begin
				validVec_q[i] <= 1'b0;
				reqVec_q[i]   <= 1'b0;
				onceVec_q[i]  <= 1'b0;
			end else if (ce) begin
				if (hit && swVal == cls_pkg::FLD_SET) validVec_q[i] <= 1'b1; // [RULE10]
				else if (hit && swVal == cls_pkg::FLD_CLR) validVec_q[i] <= 1'b0;
				if (setRq) reqVec_q[i] <= 1'b1; // [RULE10]
				else if (clrRq) reqVec_q[i] <= 1'b0;
				if (hit) onceVec_q[i] <= swData[cls_pkg::OBJ_ONCE_BIT]; // [RULE6]
			end
		end
	end

	// Read word shows two-bit fields in their set/reset codes
	assign rdData_d = {27'h0, onceVec_q[rdIdx],
		reqVec_q[rdIdx] ? cls_pkg::FLD_SET : cls_pkg::FLD_CLR,
		validVec_q[rdIdx] ? cls_pkg::FLD_SET : cls_pkg::FLD_CLR};

	always_ff @(posedge clk) begin
		if (!rst_b) rdData_q <= 32'h0;
		else if (ce && rdEn) rdData_q <= rdData_d;
	end

	AST_SET_CODE: assert property (@(posedge clk) disable iff (!rst_b) // [RULE10]
		ce && swWr && swRq == cls_pkg::FLD_SET |=> reqVec_q[$past(swIdx)])
		else $error("transmit request not set by code 10");
endmodule : cls_obj_ctrl

// File: sim/cls_xcvr_model.sv
`timescale 1ns/1ps
// -----------------------------------------------------------------
// Transceiver stand-in, one bus segment per node
// -----------------------------------------------------------------
module cls_xcvr_model #(
	parameter int DLY = 3
) (
	input  wire logic txPinA,
	input  wire logic txPinB,
	input  wire logic busDom,
	output wire logic rxPinA,
	output wire logic rxPinB
);
	// Echo of own transmit; busDom mimics a dominant bit from a foreign station
	assign #(DLY) rxPinA = txPinA & ~busDom;
	assign #(DLY) rxPinB = txPinB & ~busDom;
endmodule : cls_xcvr_model

// File: sim/can_loopback_single_try_bench.sv
`timescale 1ns/1ps
module can_loopback_single_try_bench;
	logic        clk, rst_b, awvalid, wvalid, bready, arvalid, rready;
	logic [11:0] awaddr, araddr;
	logic [31:0] wdata, rdata;
	logic [1:0]  bresp, rresp;
	logic        awready, wready, bvalid, arready, rvalid, busDom;
	logic        nodeTxA, nodeTxB, nodeRxA, nodeRxB, txPinA, txPinB, rxPinA, rxPinB;
	logic        txReqValid, frameStart, frameDone, frameError;
	logic [4:0]  txReqObj, frameObj;
	int          error_cnt, check_count, cyc;
	logic [7:0]  lb;

	cls_can_loopback u_cls_can_loopback (.clk(clk), .rst_b(rst_b), .ce(1'b1),
		.awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata),
		.wstrb(4'hf), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
		.bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
		.rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
		.nodeTxA(nodeTxA), .nodeTxB(nodeTxB), .nodeRxA(nodeRxA), .nodeRxB(nodeRxB),
		.txPinA(txPinA), .txPinB(txPinB), .rxPinA(rxPinA), .rxPinB(rxPinB),
		.txReqValid(txReqValid), .txReqObj(txReqObj), .frameStart(frameStart),
		.frameDone(frameDone), .frameError(frameError), .frameObj(frameObj));
	cls_xcvr_model u_cls_xcvr_model (.txPinA(txPinA), .txPinB(txPinB),
		.busDom(busDom), .rxPinA(rxPinA), .rxPinB(rxPinB));

	// -----------------------------------------------------------------
	// Clock, watchdog and checking
	// -----------------------------------------------------------------
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	// Whole run needs well under a thousand cycles
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			error_cnt++;
			report_and_stop();
		end
	end

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			error_cnt++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk

	task automatic report_and_stop();
		$display("checks %0d errors %0d", check_count, error_cnt);
		if (error_cnt == 0 && check_count > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : report_and_stop

	// -----------------------------------------------------------------
	// Bus and engine drivers; each starts just after a rising edge
	// -----------------------------------------------------------------
	// Readies are combinational, so they are looked at 1 ns after the edge
	task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
		logic [1:0] r;
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		forever begin
			#1;
			if (awready && wready) break;
			@(posedge clk);
		end
		@(posedge clk);
		awvalid <= 1'b0;
		wvalid <= 1'b0;
		forever begin
			#1;
			if (bvalid) break;
			@(posedge clk);
		end
		r = bresp;
		@(posedge clk);
		chk({30'h0, r}, {30'h0, er});
	endtask : wr

	task automatic rd(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e,
			input logic [1:0] er);
		logic [31:0] d;
		logic [1:0]  r;
		araddr <= a;
		arvalid <= 1'b1;
		forever begin
			#1;
			if (arready) break;
			@(posedge clk);
		end
		@(posedge clk);
		arvalid <= 1'b0;
		forever begin
			#1;
			if (rvalid) break;
			@(posedge clk);
		end
		d = rdata;
		r = rresp;
		@(posedge clk);
		chk(d & m, e);
		chk({30'h0, r}, {30'h0, er});
	endtask : rd

	// k is {start, done, error}, one pulse for one cycle
	task automatic frame(input logic [2:0] k, input logic [4:0] o);
		frameObj <= o;
		{frameStart, frameDone, frameError} <= k;
		@(posedge clk);
		{frameStart, frameDone, frameError} <= 3'h0;
		@(posedge clk);
	endtask : frame

	task automatic req(input logic [5:0] e);
		#1;
		chk({26'h0, txReqValid, txReqObj}, {26'h0, e});
		@(posedge clk);
	endtask : req

	function automatic logic [11:0] oa(input int n);
		return cls_pkg::OFF_OBJ_BASE + 12'(n * 4);
	endfunction : oa

	// -----------------------------------------------------------------
	// Main sequence
	// -----------------------------------------------------------------
	initial begin
		{rst_b, awvalid, wvalid, bready, arvalid, rready, busDom} = 7'h0;
		{nodeTxA, nodeTxB, frameStart, frameDone, frameError} = 5'h18;
		{awaddr, araddr, wdata, frameObj, error_cnt, check_count, cyc} = '0;
		repeat (20) @(posedge clk);
		rst_b <= 1'b1;
		bready <= 1'b1;
		rready <= 1'b1;
		@(posedge clk);
		rd(cls_pkg::OFF_TIM_B, 32'hffffffff, 32'h0, cls_pkg::RESP_OKAY);
		rd(oa(0), 32'h0c, 32'h04, cls_pkg::RESP_OKAY);
		// Every loop-back bit pairing; only 1/1 may loop back
		for (int i = 0; i < 4; i++) begin
			lb = {7'h0, i[1] & i[0]};
			wr(cls_pkg::OFF_TIM_A, {16'hffff, 7'h0, i[1], 8'h5a}, cls_pkg::RESP_OKAY);
			wr(cls_pkg::OFF_TIM_B, {16'hffff, 7'h0, i[0], 8'ha5}, cls_pkg::RESP_OKAY);
			rd(cls_pkg::OFF_TIM_A, 32'hffffffff, {23'h0, i[1], 8'h5a}, 2'h0);
			rd(cls_pkg::OFF_STAT, 32'h1f03, {24'h0, lb}, cls_pkg::RESP_OKAY);
			nodeTxA <= 1'b0;
			busDom <= 1'b0;
			repeat (4) @(posedge clk);
			#1;
			chk({txPinA, txPinB, nodeRxA, nodeRxB}, lb[0] ? 4'hc : 4'h5);
			@(posedge clk);
			nodeTxA <= 1'b1;
			busDom <= 1'b1;
			repeat (4) @(posedge clk);
			#1;
			chk({txPinA, txPinB, nodeRxA, nodeRxB}, lb[0] ? 4'hf : 4'hc);
			@(posedge clk);
			// Node B dominant alone must also reach both receivers in loop-back
			nodeTxB <= 1'b0;
			busDom <= 1'b0;
			repeat (4) @(posedge clk);
			#1;
			chk({txPinA, txPinB, nodeRxA, nodeRxB}, lb[0] ? 4'hc : 4'ha);
			@(posedge clk);
			nodeTxB <= 1'b1;
		end
		// Single-try object loses its request at frame start, no retry
		wr(oa(3), 32'h1a, cls_pkg::RESP_OKAY);
		req(6'h23);
		frame(3'h4, 5'd3);
		req(6'h00);
		frame(3'h1, 5'd3);
		req(6'h00);
		rd(oa(3), 32'h1c, 32'h14, cls_pkg::RESP_OKAY);
		// Ordinary object keeps its request through start and error
		wr(oa(5), 32'h0a, cls_pkg::RESP_OKAY);
		frame(3'h4, 5'd5);
		req(6'h25);
		frame(3'h1, 5'd5);
		req(6'h25);
		frame(3'h2, 5'd5);
		req(6'h00);
		// A pending request on an invalid object is not offered
		wr(oa(7), 32'h09, cls_pkg::RESP_OKAY);
		req(6'h00);
		wr(oa(7), 32'h0a, cls_pkg::RESP_OKAY);
		req(6'h27);
		wr(oa(1), 32'h0a, cls_pkg::RESP_OKAY);
		req(6'h21);
		wr(oa(1), 32'h05, cls_pkg::RESP_OKAY);
		req(6'h27);
		rd(cls_pkg::OFF_STAT, 32'h1f03, 32'h0703, cls_pkg::RESP_OKAY);
		// Unmapped word
		rd(12'h00c, 32'hffffffff, 32'h0, cls_pkg::RESP_SLVERR);
		wr(12'h00c, 32'h1, cls_pkg::RESP_SLVERR);
		report_and_stop();
	end
endmodule : can_loopback_single_try_bench
